// ---- design/clock_mode_defines.vh ----
// Purpose: Constants shared by the clock mode generator and its output divider.
// Assumes: 100 MHz system clock, 10 ns period.
// Notes: Times are kept in their own unit and converted to cycles here.
`ifndef CLOCK_MODE_DEFINES_VH
`define CLOCK_MODE_DEFINES_VH
`define CLK_PERIOD_NS 10
`define LOCK_TIME_MS 30
`define LOCK_CYCLES ((`LOCK_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define PIN_MODE_DIV2_LOW 3'h0
`define PIN_MODE_DIV4 3'h5
`define PIN_MODE_DIV2_HIGH 3'h7
`define MULT_INT_W 5
`define MULT_FRAC_W 2
`define MULT_RESET 7'h04
`define DIV_SEL_W 2
`define DIV_SEL_NONE 2'h0
`define DIV_SEL_BY2 2'h1
`define DIV_SEL_BY4 2'h3
`define DIV_SEL_RESET 2'h3
`endif

// ---- design/output_clock_divider.v ----
// Purpose: Divides the machine clock enable stream for the machine clock output pin.
// Assumes: Machine clock arrives as a one-cycle tick on clk.
// Notes: Setting 0 passes the machine clock through undivided.
`timescale 1ns/1ps
`include "clock_mode_defines.vh"
module output_clock_divider (
  input wire clk,
  input wire srst,
  input wire machine_tick,
  input wire machine_level,
  input wire [1:0] div_sel,
  output reg clk_out
);
  // Count of machine ticks within the divided period.
  reg [1:0] count_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Divider: toggles the output after the selected number of ticks.
  always @(posedge clk) begin
    if (srst) begin
      count_reg <= 2'h0;
      clk_out <= 1'b0;
    end else if (div_sel == `DIV_SEL_NONE) begin
      // Pass the machine clock level straight to the pin.
      count_reg <= 2'h0;
      clk_out <= machine_level;
    end else if (machine_tick) begin
      // Divide by two toggles every second tick, divide by four every fourth tick.
      if (count_reg == ((div_sel == `DIV_SEL_BY2) ? 2'h1 : 2'h3)) begin
        count_reg <= 2'h0;
        clk_out <= ~clk_out;
      end else begin
        count_reg <= count_reg + 2'h1;
      end
    end
  end
endmodule

// ---- design/dsp_clock_mode_generator.v ----
// Purpose: Machine clock generator with pin-strapped divide modes and a programmable multiplier.
// Assumes: The reference clock is sampled as a pin on clk; the multiplier is modelled by a phase accumulator.
// Notes: Machine clock appears as a tick pulse and a level; output pin divider resets to divide by four.
// Function
// - Decode mode pins at reset: 000,101,111.
// - Machine cycle is reference divided or multiplied.
// - Crystal oscillator enabled only when mode requests.
// - Multiplier ratio taken from clock mode register.
// - Software writes register; device applies new factor.
// - Multiplier supports integer and quarter fractions.
// - Allow up to 30 ms lock after change.
// - Output divider resets divide-by-four; 00 undivided.
`timescale 1ns/1ps
`include "clock_mode_defines.vh"
module dsp_clock_mode_generator #(
  parameter LOCK_CYCLES = `LOCK_CYCLES,
  parameter ACC_W = 16
) (
  input wire clk,
  input wire srst,
  input wire reference_clock_input,
  input wire mode_select_pin_1,
  input wire mode_select_pin_2,
  input wire mode_select_pin_3,
  input wire clock_mode_register_we,
  input wire [6:0] clock_mode_register_wdata,
  input wire pll_request,
  input wire [1:0] output_clock_divider_wdata,
  input wire output_clock_divider_we,
  output reg [6:0] clock_mode_register,
  output reg [1:0] output_clock_divider,
  output reg crystal_drive_enable,
  output reg pll_enabled,
  output reg pll_locked,
  output reg divide_by_four,
  output reg machine_tick,
  output reg machine_level,
  output wire machine_clock_output
);
  // Pin synchroniser stages for the reference clock.
  reg ref_s1_reg;
  reg ref_s2_reg;
  reg ref_s3_reg;
  // Debounced reference level and its previous value.
  reg ref_level_reg;
  // Reset-time sampling flag: the first cycle after release captures the straps.
  reg strap_pending_reg;
  // Strap pin synchroniser stages, pattern order pin 1, pin 2, pin 3.
  reg [2:0] strap_s1_reg;
  reg [2:0] strap_s2_reg;
  reg [2:0] strap_s3_reg;
  // Reference edge counter for the divided path.
  reg [1:0] ref_div_reg;
  // Lock timer.
  reg [31:0] lock_cnt_reg;
  // Phase accumulator for the multiplied path.
  reg [ACC_W-1:0] phase_reg;
  // Cycles measured per reference period and the period in use.
  reg [ACC_W-1:0] period_cnt_reg;
  reg [ACC_W-1:0] period_reg;
  // Selects the multiplied path once lock has been reached.
  reg use_pll_reg;
  // Pending source change, applied only at a machine tick.
  reg switch_pending_reg;
  wire ref_rise;
  wire [ACC_W+6:0] phase_sum;
  wire div_tick;
  wire pll_tick;

  // A qualified reference edge: second and third stages agree on a new level.
  assign ref_rise = (ref_s2_reg == ref_s3_reg) && ref_s3_reg && !ref_level_reg;

  // Multiplier step: factor in quarters accumulated against twice the period.
  // Each tick is a half machine period, so a factor of N gives 2N ticks per reference period.
  assign phase_sum = {7'h00, phase_reg} + {{ACC_W{1'b0}}, clock_mode_register};
  assign pll_tick = (phase_sum >= {6'h00, period_reg, 1'b0}) && (period_reg != {ACC_W{1'b0}});

  // Divided path tick: every reference rise for /2 tick, every second one for /4.
  assign div_tick = ref_rise && (divide_by_four ? ref_div_reg[0] : 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock input synchroniser and edge qualification.
  always @(posedge clk) begin
    if (srst) begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_s3_reg <= 1'b0;
      ref_level_reg <= 1'b0;
    end else begin
      ref_s1_reg <= reference_clock_input;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
      // Accept the new level only when the later stages agree.
      if (ref_s2_reg == ref_s3_reg) begin
        ref_level_reg <= ref_s3_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap pin synchroniser; it runs through reset so the pattern has settled at release.
  always @(posedge clk) begin
    strap_s1_reg <= {mode_select_pin_1, mode_select_pin_2, mode_select_pin_3};
    strap_s2_reg <= strap_s1_reg;
    strap_s3_reg <= strap_s2_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture, mode decode and software programming of the multiplier.
  always @(posedge clk) begin
    if (srst) begin
      strap_pending_reg <= 1'b1;
      crystal_drive_enable <= 1'b0;
      pll_enabled <= 1'b0;
      divide_by_four <= 1'b0;
      clock_mode_register <= `MULT_RESET;
      output_clock_divider <= `DIV_SEL_RESET;
    end else begin
      if (strap_pending_reg) begin
        // Straps are taken on the first edge after release, later while the last two stages differ.
        strap_pending_reg <= (strap_s2_reg != strap_s3_reg);
        pll_enabled <= 1'b0;
        case (strap_s3_reg)
          `PIN_MODE_DIV2_LOW: begin
            // Divide by two, reference from the input pin.
            divide_by_four <= 1'b0;
            crystal_drive_enable <= 1'b0;
          end
          `PIN_MODE_DIV4: begin
            // Divide by four, reference from the input pin.
            divide_by_four <= 1'b1;
            crystal_drive_enable <= 1'b0;
          end
          `PIN_MODE_DIV2_HIGH: begin
            // Divide by two with the internal oscillator running.
            divide_by_four <= 1'b0;
            crystal_drive_enable <= 1'b1;
          end
          default: begin
            // Other patterns fall back to divide by two from the input pin.
            divide_by_four <= 1'b0;
            crystal_drive_enable <= 1'b0;
          end
        endcase
      end else if (clock_mode_register_we) begin
        // A write loads the multiplier and sets the PLL mode from the request bit.
        clock_mode_register <= clock_mode_register_wdata;
        pll_enabled <= pll_request;
      end
      // The output divider field is written independently.
      if (output_clock_divider_we) begin
        output_clock_divider <= output_clock_divider_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock timer: restarts on any multiplier write and reports lock when done.
  always @(posedge clk) begin
    if (srst) begin
      lock_cnt_reg <= 32'h00000000;
      pll_locked <= 1'b0;
    end else if (clock_mode_register_we && !strap_pending_reg) begin
      lock_cnt_reg <= 32'h00000000;
      pll_locked <= 1'b0;
    end else if (pll_enabled && !pll_locked) begin
      if (lock_cnt_reg >= LOCK_CYCLES - 1) begin
        pll_locked <= 1'b1;
      end else begin
        lock_cnt_reg <= lock_cnt_reg + 32'h00000001;
      end
    end else if (!pll_enabled) begin
      pll_locked <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference period measurement and phase accumulation for the multiplier.
  always @(posedge clk) begin
    if (srst) begin
      period_cnt_reg <= {ACC_W{1'b0}};
      period_reg <= {ACC_W{1'b0}};
      phase_reg <= {ACC_W{1'b0}};
      ref_div_reg <= 2'h0;
    end else begin
      if (ref_rise) begin
        // Latch the measured period and restart the measurement.
        period_reg <= period_cnt_reg + {{(ACC_W-1){1'b0}}, 1'b1};
        period_cnt_reg <= {ACC_W{1'b0}};
        ref_div_reg <= ref_div_reg + 2'h1;
      end else if (period_cnt_reg != {ACC_W{1'b1}}) begin
        period_cnt_reg <= period_cnt_reg + {{(ACC_W-1){1'b0}}, 1'b1};
      end
      // Wrap the phase by twice the measured period whenever a multiplied tick is issued.
      if (pll_tick) begin
        phase_reg <= phase_sum[ACC_W-1:0] - {period_reg[ACC_W-2:0], 1'b0};
      end else begin
        phase_reg <= phase_sum[ACC_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and machine tick; switching happens only on a tick.
  always @(posedge clk) begin
    if (srst) begin
      use_pll_reg <= 1'b0;
      switch_pending_reg <= 1'b0;
      machine_tick <= 1'b0;
      machine_level <= 1'b0;
    end else begin
      // Request a change of source when lock state and mode disagree.
      switch_pending_reg <= (pll_enabled && pll_locked) != use_pll_reg;
      machine_tick <= use_pll_reg ? pll_tick : div_tick;
      if (use_pll_reg ? pll_tick : div_tick) begin
        machine_level <= ~machine_level;
        // Changing source right at a tick keeps every half period whole.
        if (switch_pending_reg) begin
          use_pll_reg <= pll_enabled && pll_locked;
        end
      end
    end
  end

  // Output pin divider driven by the machine clock.
  output_clock_divider u_out_div (
    .clk(clk),
    .srst(srst),
    .machine_tick(machine_tick),
    .machine_level(machine_level),
    .div_sel(output_clock_divider),
    .clk_out(machine_clock_output)
  );
endmodule

// ---- verification/ref_clock_source.sv ----
// Purpose: Reference clock source that drives the reference clock pin.
// Assumes: The device is fully static, so the source may stop.
// Notes: The half period is set by parameter.
`timescale 1ns/1ps
module ref_clock_source #(parameter HALF_NS = 40) (
  input wire run,
  output logic ref_clk
);
  // Toggles while run is high and rests low when stopped.
  initial ref_clk = 1'b0;
  always #(HALF_NS) ref_clk = run ? ~ref_clk : 1'b0;
endmodule

// ---- verification/clock_mode_checker_assertions.sv ----
// Purpose: Port checker for the clock mode generator.
// Assumes: The lock count is handed on from the design.
// Notes: Bound to the top module at the foot.
`timescale 1ns/1ps
`include "clock_mode_defines.vh"
module clock_mode_checker #(parameter LOCK_CYCLES = 20) (
  input wire clk,
  input wire srst,
  input wire mode_select_pin_1,
  input wire mode_select_pin_2,
  input wire mode_select_pin_3,
  input wire clock_mode_register_we,
  input wire [6:0] clock_mode_register_wdata,
  input wire pll_request,
  input wire [6:0] clock_mode_register,
  input wire [1:0] output_clock_divider,
  input wire crystal_drive_enable,
  input wire pll_enabled,
  input wire pll_locked,
  input wire divide_by_four
);
  reg first_reg;
  reg [31:0] age_reg;
  wire [2:0] strap = {mode_select_pin_1, mode_select_pin_2, mode_select_pin_3};
  wire take = clock_mode_register_we && !first_reg;
  // Marks the strap cycle and counts cycles since the last accepted write.
  always @(posedge clk) begin
    first_reg <= srst;
    if (srst) age_reg <= 32'h80000000;
    else if (take) age_reg <= 32'h0;
    else if (!age_reg[31]) age_reg <= age_reg + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_pll_write; take && pll_request; endsequence
  sequence s_relock; pll_enabled && !pll_locked; endsequence
  property p_div4; first_reg && strap == `PIN_MODE_DIV4 |=> divide_by_four && !crystal_drive_enable; endproperty
  a_div4: assert property (p_div4) else $error("div4 strap");
  property p_xtal; first_reg && strap == `PIN_MODE_DIV2_HIGH |=> crystal_drive_enable && !divide_by_four; endproperty
  a_xtal: assert property (p_xtal) else $error("xtal strap");
  property p_div2; first_reg && strap == `PIN_MODE_DIV2_LOW |=> !crystal_drive_enable && !divide_by_four; endproperty
  a_div2: assert property (p_div2) else $error("div2 strap");
  property p_rst; first_reg |-> clock_mode_register == `MULT_RESET && output_clock_divider == `DIV_SEL_RESET; endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_wr; take |=> clock_mode_register == $past(clock_mode_register_wdata); endproperty
  a_wr: assert property (p_wr) else $error("multiplier write");
  property p_relock; s_pll_write |=> s_relock; endproperty
  a_relock: assert property (p_relock) else $error("relock");
  property p_off; take && !pll_request |=> !pll_enabled && !pll_locked; endproperty
  a_off: assert property (p_off) else $error("pll off");
  property p_late; $rose(pll_locked) |-> age_reg == LOCK_CYCLES; endproperty
  a_late: assert property (p_late) else $error("lock early");
  property p_due; pll_enabled && age_reg == LOCK_CYCLES |-> pll_locked; endproperty
  a_due: assert property (p_due) else $error("lock late");
endmodule
bind dsp_clock_mode_generator clock_mode_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (.*);

// ---- verification/test_dsp_clock_mode_generator.sv ----
// Purpose: Self-checking bench for the clock mode generator.
// Assumes: Lock count cut to 20 cycles; reference period 8 cycles.
// Notes: Strap rows first, then writes, lock and output divider.
`timescale 1ns/1ps
`include "clock_mode_defines.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s %0h %0h", n, e, g); end end
module test_dsp_clock_mode_generator;
  localparam LOCK = 20;
  logic clk = 0, srst = 1, run = 1, reference_clock_input;
  logic mode_select_pin_1 = 0, mode_select_pin_2 = 0, mode_select_pin_3 = 0, pll_request = 0;
  logic clock_mode_register_we = 0, output_clock_divider_we = 0;
  logic [6:0] clock_mode_register_wdata = 0, clock_mode_register;
  logic [1:0] output_clock_divider_wdata = 0, output_clock_divider;
  logic crystal_drive_enable, pll_enabled, pll_locked, divide_by_four;
  logic machine_tick, machine_level, machine_clock_output, q, v;
  int num_errors = 0, checks = 0, n, m, l, e;
  // Strap rows: pattern, expected divide_by_four, expected crystal enable.
  logic [4:0] rows [4] = '{5'h00, 5'h16, 5'h1D, 5'h0C};
  logic [6:0] mults [4] = '{7'h04, 7'h0A, 7'h09, 7'h0B};
  always #5 clk = ~clk;
  ref_clock_source src_u (.run(run), .ref_clk(reference_clock_input));
  dsp_clock_mode_generator #(.LOCK_CYCLES(LOCK)) dut_u (.*);
  task automatic cyc(int k); repeat (k) @(posedge clk); #1; endtask
  // Reset with the given straps and wait until the outputs settle.
  task automatic boot(logic [2:0] s);
    srst = 1;
    {mode_select_pin_1, mode_select_pin_2, mode_select_pin_3} = s;
    cyc(3);
    srst = 0;
    cyc(2);
  endtask
  task automatic wr(logic [6:0] d, logic p);
    clock_mode_register_wdata = d;
    pll_request = p;
    clock_mode_register_we = 1;
    cyc(1);
    clock_mode_register_we = 0;
    cyc(1);
  endtask
  // Counts ticks, output pin changes and level changes over k cycles.
  task automatic ticks(int k);
    n = 0; m = 0; l = 0;
    q = machine_clock_output;
    v = machine_level;
    repeat (k) begin
      @(negedge clk);
      n += machine_tick;
      m += (machine_clock_output != q);
      l += (machine_level != v);
      q = machine_clock_output;
      v = machine_level;
    end
    cyc(1);
  endtask
  task automatic conclude;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Stops a hung run.
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
  initial begin
    foreach (rows[i]) begin
      boot(rows[i][4:2]);
      `CHK("div4", rows[i][1], divide_by_four)
      `CHK("xtal", rows[i][0], crystal_drive_enable)
      `CHK("mult", `MULT_RESET, clock_mode_register)
      `CHK("odiv", `DIV_SEL_RESET, output_clock_divider)
      ticks(800);
      e = rows[i][1] ? 50 : 100;
      `CHK("rate", 1'b1, n > e - 2 && n < e + 2)
    end
    // A write on the strap cycle is refused.
    srst = 1;
    cyc(3);
    srst = 0;
    wr(7'h0A, 1);
    `CHK("refuse", `MULT_RESET, clock_mode_register)
    foreach (mults[i]) begin
      wr(mults[i], 1);
      `CHK("mult", mults[i], clock_mode_register)
      `CHK("lock0", 1'b0, pll_locked)
      cyc(LOCK - 2);
      `CHK("lock0", 1'b0, pll_locked)
      cyc(1);
      `CHK("lock1", 1'b1, pll_locked)
      // Let the source move to the multiplied clock at its next tick.
      cyc(12);
      ticks(800);
      e = mults[i] * 50;
      `CHK("prate", 1'b1, n > e - 4 && n < e + 4)
    end
    wr(7'h08, 1);
    cyc(10);
    wr(7'h0C, 1);
    cyc(LOCK - 2);
    `CHK("restart", 1'b0, pll_locked)
    wr(7'h04, 0);
    `CHK("pll", 1'b0, pll_enabled)
    for (int j = 0; j < 3; j++) begin
      output_clock_divider_wdata = (j == 2) ? `DIV_SEL_BY4 : j[1:0];
      output_clock_divider_we = 1;
      cyc(1);
      output_clock_divider_we = 0;
      `CHK("odivw", output_clock_divider_wdata, output_clock_divider)
      ticks(800);
      e = m * (1 << j);
      `CHK("cko", 1'b1, e > l - 6 && e < l + 6)
    end
    // With the reference stopped in divided mode no machine tick may appear.
    run = 0;
    cyc(10);
    ticks(200);
    `CHK("stop", 0, n)
    conclude();
  end
endmodule
